// >>> hdl/msam_mapper.v
// memory space access mapper: program/data address mapping, byte lanes, alignment traps
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// ************************************************************
// Summary of operation
// - 24-bit program address from pc or table
// - user program space limited to lower half
// - program word split lower even, upper odd
// - pc stays even, steps by two
// - reset starts at zero, vectors below 0x200
// - two vector tables flagged by address range
// - config words copied to registers at reset
// - top four flash words hold configuration
// - 16-bit byte data addresses, separate generators
// - low half linear, high half extended window
// - page plus address forms 24-bit effective address
// - program view uses only read page
// - upper ram via window, external port via window only with the large package
// - low byte even, high byte odd
// - post-increment by one byte, two word
// - byte read selects lane, low bits
// - shared word decode, per-lane write strobes
// - odd word access raises address error
// - misaligned write suppressed, trap follows instruction
// - byte load keeps high byte
// - sign and zero extend to sixteen bits
// - read and write page registers reset to one, table page to zero
// - unimplemented special register reads return zero
// ************************************************************
`include "msam_map.vh"
module msam_mapper (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // axi4-lite write address / data / response
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address / data
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // program side from cpu
    input wire [22:0] pc_in,
    input wire pc_step,
    input wire pc_down,
    input wire pc_load,
    input wire table_op,
    input wire [15:0] table_offset,
    output reg [23:0] prog_addr_r,
    output reg prog_upper_r,
    output reg prog_cfg_space_r,
    output reg prog_deny_r,
    output reg prog_vector_r,
    output reg prog_alt_vector_r,
    output reg prog_cfg_word_r,
    // config word load from flash
    input wire [15:0] cfg_flash_data,
    output reg [23:0] cfg_fetch_addr_r,
    output reg cfg_loading_r,
    // data read generator
    input wire rd_req,
    input wire rd_byte,
    input wire [15:0] rd_addr,
    input wire rd_post_inc,
    input wire [15:0] rd_mem_data,
    input wire rd_sfr_hit,
    input wire rd_sign_ext,
    input wire rd_zero_ext,
    input wire [15:0] rd_dest_old,
    output reg [23:0] rd_ea_r,
    output reg rd_window_r,
    output reg rd_psv_r,
    output reg rd_ext_port_r,
    output reg [15:0] rd_addr_next_r,
    output reg [15:0] rd_result_r,
    output reg rd_valid_r,
    // data write generator
    input wire wr_req,
    input wire wr_byte,
    input wire [15:0] wr_addr,
    input wire wr_post_inc,
    input wire [15:0] wr_data,
    output reg [23:0] wr_ea_r,
    output reg wr_window_r,
    output reg wr_ext_port_r,
    output reg [1:0] wr_lane_en_r,
    output reg [15:0] wr_data_out_r,
    output reg [15:0] wr_addr_next_r,
    // address error trap
    output reg addr_err_r,
    output reg trap_req_r
);
    // ************************************************************
    // reset synchroniser
    // ************************************************************
    reg rst_meta_r; // first stage, read only by second
    reg rst_sync_r; // released reset, active high when out of reset
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire rstn = rst_sync_r;
    // ************************************************************
    // software registers
    // ************************************************************
    reg [9:0] read_page_select_r; // read page
    reg [8:0] write_page_select_r; // write page
    reg [7:0] table_page_select_r; // table page
    reg big_pkg_r; // large memory / package selection
    reg [15:0] cfg_reg_r [0:3]; // configuration word copies
    reg [31:0] trap_count_r; // count of address errors
    // ************************************************************
    // axi4-lite slave; one write and one read outstanding
    // ************************************************************
    reg aw_got_r; // address captured
    reg w_got_r; // data captured
    reg [11:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            read_page_select_r <= {1'b0, `MSAM_PAGE_RST};
            write_page_select_r <= `MSAM_PAGE_RST;
            table_page_select_r <= `MSAM_TPAGE_RST;
            big_pkg_r <= 1'b1;
        end else begin
            // capture address and data in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                // only the low two lanes carry page values
                case (aw_addr_r)
                    `MSAM_OFS_RPAGE: begin
                        if (w_strb_r[0]) read_page_select_r[7:0] <= w_data_r[7:0];
                        if (w_strb_r[1]) read_page_select_r[9:8] <= w_data_r[9:8];
                    end
                    `MSAM_OFS_WPAGE: begin
                        if (w_strb_r[0]) write_page_select_r[7:0] <= w_data_r[7:0];
                        if (w_strb_r[1]) write_page_select_r[8] <= w_data_r[8];
                    end
                    `MSAM_OFS_TPAGE: begin
                        if (w_strb_r[0]) table_page_select_r <= w_data_r[7:0];
                    end
                    `MSAM_OFS_CTRL: begin
                        if (w_strb_r[0]) big_pkg_r <= w_data_r[`MSAM_CTRL_BIG_BIT];
                    end
                    default: begin
                        s_axi_bresp <= 2'h2; // unmapped or read-only: slverr
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // read channel: answer one cycle after address taken
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `MSAM_OFS_RPAGE: rd_mux = {22'h000000, read_page_select_r};
            `MSAM_OFS_WPAGE: rd_mux = {23'h000000, write_page_select_r};
            `MSAM_OFS_TPAGE: rd_mux = {24'h000000, table_page_select_r};
            `MSAM_OFS_CTRL: rd_mux = {31'h00000000, big_pkg_r};
            `MSAM_OFS_STAT: rd_mux = {29'h00000000, cfg_loading_r, trap_req_r, addr_err_r};
            12'h014: rd_mux = {16'h0000, cfg_reg_r[0]};
            12'h018: rd_mux = {16'h0000, cfg_reg_r[1]};
            12'h01c: rd_mux = {16'h0000, cfg_reg_r[2]};
            12'h020: rd_mux = {16'h0000, cfg_reg_r[3]};
            `MSAM_OFS_TRAP: rd_mux = trap_count_r;
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
    // ************************************************************
    // configuration word load after reset
    // ************************************************************
    reg [2:0] cfg_idx_r; // word being fetched, 4 = done
    reg cfg_pend_r; // fetch issued, data next cycle
    wire [23:0] cfg_base = big_pkg_r ? `MSAM_CFG_LARGE : `MSAM_CFG_SMALL;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_idx_r <= 3'h0;
            cfg_pend_r <= 1'b0;
            cfg_loading_r <= 1'b1;
            cfg_fetch_addr_r <= 24'h000000;
            cfg_reg_r[0] <= 16'h0000;
            cfg_reg_r[1] <= 16'h0000;
            cfg_reg_r[2] <= 16'h0000;
            cfg_reg_r[3] <= 16'h0000;
        end else if (cfg_loading_r) begin
            // one word per two cycles: address out, then data back
            if (!cfg_pend_r) begin
                cfg_fetch_addr_r <= cfg_base + {20'h00000, cfg_idx_r[1:0], 1'b0, 1'b0} / 24'h2;
                cfg_pend_r <= 1'b1;
            end else begin
                cfg_reg_r[cfg_idx_r[1:0]] <= cfg_flash_data;
                cfg_pend_r <= 1'b0;
                cfg_idx_r <= cfg_idx_r + 3'h1;
                if (cfg_idx_r == 3'h3) cfg_loading_r <= 1'b0;
            end
        end
    end
    // ************************************************************
    // program address generation
    // ************************************************************
    reg [23:0] pa_nxt;
    always @* begin
        if (table_op)
            pa_nxt = {table_page_select_r, table_offset};
        else if (pc_load)
            pa_nxt = {1'b0, pc_in[22:1], 1'b0};
        else if (pc_step)
            pa_nxt = pc_down ? prog_addr_r - 24'h2 : prog_addr_r + 24'h2;
        else
            pa_nxt = prog_addr_r;
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prog_addr_r <= `MSAM_PC_RESET;
            prog_upper_r <= 1'b0;
            prog_cfg_space_r <= 1'b0;
            prog_deny_r <= 1'b0;
            prog_vector_r <= 1'b0;
            prog_alt_vector_r <= 1'b0;
            prog_cfg_word_r <= 1'b0;
        end else begin
            prog_addr_r <= pa_nxt;
            prog_upper_r <= pa_nxt[0];
            // only tables with page bit 7 may reach upper half
            prog_cfg_space_r <= table_op && table_page_select_r[`MSAM_TPAGE_CFG_BIT];
            prog_deny_r <= !table_op && (pa_nxt > `MSAM_USER_TOP);
            prog_vector_r <= pa_nxt < `MSAM_VEC_END;
            prog_alt_vector_r <= pa_nxt >= `MSAM_AIVT_LO && pa_nxt <= `MSAM_AIVT_HI;
            prog_cfg_word_r <= pa_nxt >= cfg_base && pa_nxt < cfg_base + 24'h8;
        end
    end
    // ************************************************************
    // data address generation and alignment check
    // ************************************************************
    wire rd_misalign = rd_req && !rd_byte && rd_addr[0];
    wire wr_misalign = wr_req && !wr_byte && wr_addr[0];
    wire rd_win = rd_addr[15];
    wire wr_win = wr_addr[15];
    // page bit 9 of the read page selects the program view
    wire rd_psv = rd_win && read_page_select_r[9];
    wire [23:0] rd_ea = {rd_win ? read_page_select_r[8:0] : 9'h000, rd_addr[14:0]};
    wire [23:0] wr_ea = wr_win ? {write_page_select_r, wr_addr[14:0]} : {8'h00, wr_addr};
    wire [23:0] ext_max = big_pkg_r ? `MSAM_EXT_MAX_BIG : `MSAM_EXT_MAX_SMALL;
    reg [7:0] rd_lane;
    reg [15:0] rd_res;
    always @* begin
        rd_lane = rd_addr[0] ? rd_mem_data[15:8] : rd_mem_data[7:0];
        // unimplemented special registers read as zero
        if (!rd_win && rd_addr <= `MSAM_SFR_TOP && !rd_sfr_hit)
            rd_res = 16'h0000;
        else if (!rd_byte)
            rd_res = rd_mem_data;
        else if (rd_sign_ext)
            rd_res = {{8{rd_lane[7]}}, rd_lane};
        else if (rd_zero_ext)
            rd_res = {8'h00, rd_lane};
        else
            rd_res = {rd_dest_old[15:8], rd_lane};
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ea_r <= 24'h000000;
            rd_window_r <= 1'b0;
            rd_psv_r <= 1'b0;
            rd_ext_port_r <= 1'b0;
            rd_addr_next_r <= 16'h0000;
            rd_result_r <= 16'h0000;
            rd_valid_r <= 1'b0;
            wr_ea_r <= 24'h000000;
            wr_window_r <= 1'b0;
            wr_ext_port_r <= 1'b0;
            wr_lane_en_r <= 2'h0;
            wr_data_out_r <= 16'h0000;
            wr_addr_next_r <= 16'h0000;
            addr_err_r <= 1'b0;
            trap_req_r <= 1'b0;
            trap_count_r <= 32'h00000000;
        end else begin
            rd_ea_r <= rd_ea;
            rd_window_r <= rd_win;
            rd_psv_r <= rd_psv;
            // window pages past internal ram go to the external port, outside the program view and only with the large package
            rd_ext_port_r <= rd_win && !rd_psv && |rd_ea[23:17] && rd_ea <= ext_max;
            rd_addr_next_r <= rd_post_inc ? rd_addr + (rd_byte ? 16'h1 : 16'h2) : rd_addr;
            rd_result_r <= rd_res;
            rd_valid_r <= rd_req;
            wr_ea_r <= wr_ea;
            wr_window_r <= wr_win;
            wr_ext_port_r <= wr_win && |wr_ea[23:17] && wr_ea <= ext_max;
            // byte writes hit one lane, misaligned words none
            if (!wr_req || wr_misalign)
                wr_lane_en_r <= 2'h0;
            else if (wr_byte)
                wr_lane_en_r <= wr_addr[0] ? 2'h2 : 2'h1;
            else
                wr_lane_en_r <= 2'h3;
            wr_data_out_r <= wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
            wr_addr_next_r <= wr_post_inc ? wr_addr + (wr_byte ? 16'h1 : 16'h2) : wr_addr;
            addr_err_r <= rd_misalign || wr_misalign;
            // trap taken after the instruction, one cycle later
            trap_req_r <= addr_err_r;
            if (addr_err_r)
                trap_count_r <= trap_count_r + 32'h1;
        end
    end
endmodule

// >>> hdl/msam_map.vh
// register offsets, fields, reset values and memory map constants for the access mapper
`ifndef MSAM_MAP_VH
`define MSAM_MAP_VH
// ************************************************************
// register byte offsets on the axi4-lite slave
// ************************************************************
`define MSAM_OFS_RPAGE 12'h000
`define MSAM_OFS_WPAGE 12'h004
`define MSAM_OFS_TPAGE 12'h008
`define MSAM_OFS_CTRL 12'h00c
`define MSAM_OFS_STAT 12'h010
`define MSAM_OFS_CFG0 12'h014
`define MSAM_OFS_TRAP 12'h024
// ************************************************************
// reset values and field positions
// ************************************************************
`define MSAM_PAGE_RST 9'h001
`define MSAM_TPAGE_RST 8'h00
`define MSAM_TPAGE_CFG_BIT 7
`define MSAM_CTRL_BIG_BIT 0
// ************************************************************
// program space map
// ************************************************************
`define MSAM_PC_RESET 24'h000000
`define MSAM_PC_GOTO_ARG 24'h000002
`define MSAM_IVT_LO 24'h000004
`define MSAM_AIVT_LO 24'h000100
`define MSAM_AIVT_HI 24'h0001ff
`define MSAM_VEC_END 24'h000200
`define MSAM_USER_TOP 24'h7fffff
`define MSAM_CFG_SMALL 24'h0157f8
`define MSAM_CFG_LARGE 24'h02abf8
`define MSAM_CFG_WORDS 4
// ************************************************************
// data space map
// ************************************************************
`define MSAM_DS_WIN_BASE 16'h8000
`define MSAM_SFR_TOP 16'h07ff
`define MSAM_RAM_LIN_TOP 16'h77ff
`define MSAM_EXT_MAX_BIG 24'hffffff
`define MSAM_EXT_MAX_SMALL 24'h00ffff
`endif

// >>> bench/msam_mapper_sva.sv
// concurrent checks on the access mapper ports
`timescale 1ns/1ps
module msam_mapper_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // read generator
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic [15:0] rd_addr,
    input wire logic rd_post_inc,
    input wire logic [15:0] rd_mem_data,
    input wire logic rd_sfr_hit,
    input wire logic rd_sign_ext,
    input wire logic rd_zero_ext,
    input wire logic [15:0] rd_dest_old,
    input wire logic rd_valid_r,
    input wire logic rd_window_r,
    input wire logic [15:0] rd_addr_next_r,
    input wire logic [15:0] rd_result_r,
    // write generator and trap
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic [15:0] wr_addr,
    input wire logic [1:0] wr_lane_en_r,
    input wire logic addr_err_r,
    input wire logic trap_req_r
);
    // ****
    // decoded request conditions
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // word access at an odd address on either generator
    wire mis = (rd_req && !rd_byte && rd_addr[0]) || (wr_req && !wr_byte && wr_addr[0]);
    // unimplemented register hole reads as zero
    wire hole = (rd_addr <= 16'h07ff) && !rd_sfr_hit;
    wire [7:0] sel = rd_addr[0] ? rd_mem_data[15:8] : rd_mem_data[7:0];
    wire plain = rd_req && rd_byte && !rd_sign_ext && !rd_zero_ext && !hole;
    wire [15:0] step = rd_addr + (rd_byte ? 16'h0001 : 16'h0002);
    // no lane at all on a misaligned word write
    wire [1:0] lane = wr_byte ? {wr_addr[0], !wr_addr[0]} : {2{!wr_addr[0]}};
    sequence s_err_trap;
        addr_err_r ##1 trap_req_r;
    endsequence
    property p_trap; mis |=> s_err_trap; endproperty
    a_trap: assert property (p_trap)
        else $error("misaligned word missed error or trap");
    property p_no_err; !mis |=> !addr_err_r; endproperty
    a_no_err: assert property (p_no_err)
        else $error("address error without cause");
    property p_window; rd_req |=> rd_valid_r && rd_window_r == $past(rd_addr[15]); endproperty
    a_window: assert property (p_window)
        else $error("read window flag wrong");
    property p_post; rd_req && rd_post_inc |=> rd_addr_next_r == $past(step); endproperty
    a_post: assert property (p_post)
        else $error("post increment step wrong");
    property p_byte; plain |=> rd_result_r == {$past(rd_dest_old[15:8]), $past(sel)}; endproperty
    a_byte: assert property (p_byte)
        else $error("byte load lane or high byte wrong");
    property p_sext; rd_req && rd_byte && rd_sign_ext && !hole |=>
        rd_result_r[15:8] == {8{$past(sel[7])}}; endproperty
    a_sext: assert property (p_sext)
        else $error("sign extension wrong");
    property p_hole; rd_req && hole |=> rd_result_r == 16'h0000; endproperty
    a_hole: assert property (p_hole)
        else $error("register hole read not zero");
    property p_lane; wr_req |=> wr_lane_en_r == $past(lane); endproperty
    a_lane: assert property (p_lane)
        else $error("write lane enables wrong");
endmodule

// >>> bench/msam_mem_model.sv
// memory array model answering the read generator and config fetch
`timescale 1ns/1ps
module msam_mem_model (
    // clock
    input wire logic core_clk,
    // requests from the mapper side
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    input wire logic [23:0] cfg_fetch_addr_r,
    // data returned
    output logic [15:0] rd_mem_data,
    output logic [15:0] cfg_flash_data
);
    logic [15:0] idle_q = 16'h0000; // moving junk so idle data is never trusted
    always @(posedge core_clk) begin
        idle_q <= idle_q + 16'h3b1d;
    end
    assign cfg_flash_data = cfg_fetch_addr_r[15:0] ^ 16'hc3e1;
    // whole word by word address, lane choice left to the mapper
    assign rd_mem_data = rd_req ? ({rd_addr[15:1], 1'b0} ^ 16'h5a3c) : idle_q;
endmodule

// >>> bench/msam_mapper_tb.sv
// self-checking bench for the memory space access mapper
`timescale 1ns/1ps
`include "msam_map.vh"
module msam_mapper_tb;
    // ****
    // bench signals
    // ****
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg [11:0] awa = 12'h000, ara = 12'h000;
    reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    reg [31:0] wd = 32'h0, got;
    reg [22:0] pc = 23'h0;
    reg pst = 1'b0, pdn = 1'b0, pld = 1'b0, top = 1'b0, rq = 1'b0, rb = 1'b0, rpi = 1'b0;
    reg rsh = 1'b0, rse = 1'b0, rze = 1'b0, wq = 1'b0, wb = 1'b0, wpi = 1'b0;
    reg [15:0] tof = 16'h0, ra = 16'h0, rold = 16'h0, wa = 16'h0, wdt = 16'h0;
    reg [9:0] rpg = 10'h001; // read page in force
    reg [1:0] resp;
    wire awr, wry, bv, arr, rv, cfl, rvl, rwin, rpsv, aerr, trq;
    wire [1:0] br, rr, lane;
    wire [31:0] rdat;
    wire [15:0] mem_d, cfg_d, res, rnx, wnx;
    wire [23:0] cfa, rea;
    integer err_count = 0, n_compared = 0, cyc = 0, mis_n = 0, i, j;
    logic [15:0] exp_q[$]; // expected read results in order
    msam_mapper dut_u (
        .core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wry), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .pc_in(pc), .pc_step(pst),
        .pc_down(pdn), .pc_load(pld), .table_op(top), .table_offset(tof), .prog_addr_r(),
        .prog_upper_r(), .prog_cfg_space_r(), .prog_deny_r(), .prog_vector_r(),
        .prog_alt_vector_r(), .prog_cfg_word_r(), .cfg_flash_data(cfg_d),
        .cfg_fetch_addr_r(cfa), .cfg_loading_r(cfl), .rd_req(rq), .rd_byte(rb), .rd_addr(ra),
        .rd_post_inc(rpi), .rd_mem_data(mem_d), .rd_sfr_hit(rsh), .rd_sign_ext(rse),
        .rd_zero_ext(rze), .rd_dest_old(rold), .rd_ea_r(rea), .rd_window_r(rwin),
        .rd_psv_r(rpsv), .rd_ext_port_r(), .rd_addr_next_r(rnx), .rd_result_r(res),
        .rd_valid_r(rvl), .wr_req(wq), .wr_byte(wb), .wr_addr(wa), .wr_post_inc(wpi),
        .wr_data(wdt), .wr_ea_r(), .wr_window_r(), .wr_ext_port_r(), .wr_lane_en_r(lane),
        .wr_data_out_r(), .wr_addr_next_r(wnx), .addr_err_r(aerr), .trap_req_r(trq));
    msam_mem_model mem_u (.core_clk(core_clk), .rd_req(rq), .rd_addr(ra),
        .cfg_fetch_addr_r(cfa), .rd_mem_data(mem_d), .cfg_flash_data(cfg_d));
    initial forever #20 core_clk = ~core_clk;
    // hang guard, the run needs under two thousand cycles
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            wrap_up;
        end
    end
    task cmp_reg(input [31:0] g, input [31:0] x);
        n_compared = n_compared + 1;
        if (g !== x) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task cmp_map(input [23:0] g, input [23:0] x);
        n_compared = n_compared + 1;
        if (g !== x) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // address and data offered together, each dropped once taken
    task axi_wr(input [11:0] a, input [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wry) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wry));
        do @(posedge core_clk); while (!bv);
        resp = br;
        bry <= 1'b0;
        @(posedge core_clk);
    endtask
    task axi_rd(input [11:0] a);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge core_clk); while (!arr);
        arv <= 1'b0;
        do @(posedge core_clk); while (!rv);
        got = rdat;
        resp = rr;
        rry <= 1'b0;
        @(posedge core_clk);
    endtask
    // one random read and write request together, checked against the model
    task map_op;
        reg [31:0] r;
        reg [15:0] a1, a2, w, e;
        reg [7:0] b;
        reg [1:0] x;
        reg rm, wm;
        r = $urandom;
        {a1, a2} = $urandom;
        if (r[8]) a1[15:11] = 5'h00; // steer some reads into the register hole
        x = r[5:4] % 2'd3;
        rq <= 1'b1;
        rb <= r[0];
        ra <= a1;
        rpi <= r[2];
        rsh <= r[3];
        rse <= x == 2'd1;
        rze <= x == 2'd2;
        rold <= a2;
        wq <= 1'b1;
        wb <= r[1];
        wa <= a2;
        wpi <= r[2];
        wdt <= a1;
        pc <= {14'h0, a1[8:0]};
        {pst, pdn, pld, top} <= r[13:10];
        tof <= {7'h0, a2[8:0]};
        w = {a1[15:1], 1'b0} ^ 16'h5a3c;
        b = a1[0] ? w[15:8] : w[7:0];
        rm = !r[0] && a1[0];
        wm = !r[1] && a2[0];
        if (a1 <= 16'h07ff && !r[3]) e = 16'h0000;
        else if (!r[0]) e = w;
        else if (x == 2'd1) e = {{8{b[7]}}, b};
        else if (x == 2'd2) e = {8'h00, b};
        else e = {a2[15:8], b};
        if (!rm) exp_q.push_back(e);
        if (rm || wm) mis_n = mis_n + 1;
        @(posedge core_clk);
        rq <= 1'b0;
        wq <= 1'b0;
        @(negedge core_clk);
        if (!rm) cmp_map(res, exp_q.pop_front());
        e = {10'h0, 1'b1, a1[15], a1[15] & rpg[9], rm | wm, 2'b00};
        e[1:0] = r[1] ? {a2[0], !a2[0]} : {2{!a2[0]}};
        cmp_map({10'h0, rvl, rwin, rpsv, aerr, lane}, e);
        cmp_map(rea, a1[15] ? {rpg[8:0], a1[14:0]} : a1);
        if (r[2]) cmp_map(rnx, a1 + (r[0] ? 16'h1 : 16'h2));
        if (r[2]) cmp_map(wnx, a2 + (r[1] ? 16'h1 : 16'h2));
        @(negedge core_clk);
        cmp_map({15'h0, trq}, {15'h0, rm | wm});
        @(posedge core_clk);
    endtask
    initial begin
        i = $urandom(64);
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (i = 0; i < 40 && cfl !== 1'b0; i = i + 1) @(posedge core_clk);
        cmp_reg({31'h0, cfl}, 32'h0);
        for (i = 0; i < 9; i = i + 1) begin
            axi_rd({i[9:0], 2'b00});
            j = i < 5 ? i != 2 && i != 4 : (`MSAM_CFG_LARGE + 2 * i - 10) & 16'hffff ^ 16'hc3e1;
            cmp_reg(got, j);
        end
        $display("test reset_values done");
        axi_rd(12'h100);
        cmp_reg({30'h0, resp}, 32'h2);
        cmp_reg(got, 32'h0);
        axi_wr(`MSAM_OFS_STAT, 32'h7);
        cmp_reg({30'h0, resp}, 32'h2);
        $display("test bus_refusal done");
        // program view on, then off, with the write page set against it
        for (j = 0; j < 2; j = j + 1) begin
            rpg = j ? 10'h001 : 10'h201;
            axi_wr(`MSAM_OFS_RPAGE, {22'h0, rpg});
            axi_wr(`MSAM_OFS_WPAGE, j ? 32'h1ff : 32'h0);
            axi_rd(`MSAM_OFS_RPAGE);
            cmp_reg(got, {22'h0, rpg});
            repeat (40) map_op;
        end
        $display("test mapping done");
        axi_rd(`MSAM_OFS_TRAP);
        cmp_reg(got, mis_n);
        $display("test trap_count done");
        wrap_up;
    end
endmodule
bind msam_mapper msam_mapper_sva chk_u (.core_clk(core_clk), .resetn(resetn), .rd_req(rd_req),
    .rd_byte(rd_byte), .rd_addr(rd_addr), .rd_post_inc(rd_post_inc), .rd_mem_data(rd_mem_data),
    .rd_sfr_hit(rd_sfr_hit), .rd_sign_ext(rd_sign_ext), .rd_zero_ext(rd_zero_ext),
    .rd_dest_old(rd_dest_old), .rd_valid_r(rd_valid_r), .rd_window_r(rd_window_r),
    .rd_addr_next_r(rd_addr_next_r), .rd_result_r(rd_result_r), .wr_req(wr_req),
    .wr_byte(wr_byte), .wr_addr(wr_addr), .wr_lane_en_r(wr_lane_en_r),
    .addr_err_r(addr_err_r), .trap_req_r(trap_req_r));
